// ---- hdl/pcl_defs.vh ----
// Constants for the transceiver control and strap pin block
`ifndef PCL_DEFS_VH
`define PCL_DEFS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PCL_ADDR_CTRL 12'h000
`define PCL_ADDR_LEDCFG 12'h004
`define PCL_ADDR_STATUS 12'h008
`define PCL_ADDR_STRAPS 12'h00c

// ****************************************
// Control register fields
// ****************************************
`define PCL_CTRL_SWRST 0
`define PCL_CTRL_SLEEP_OVR 1
`define PCL_CTRL_SLEEP_VAL 2
`define PCL_CTRL_PAUSE 3
`define PCL_CTRL_RST_VAL 4'h0

// ****************************************
// Indicator configuration: four bits per pin
// ****************************************
`define PCL_LED_W 4
`define PCL_LEDCFG_RST 12'h210
`define PCL_LED_LINK 4'h0
`define PCL_LED_ACT 4'h1
`define PCL_LED_SPEED 4'h2
`define PCL_LED_DUPLEX 4'h3
`define PCL_LED_ON 4'h4
`define PCL_LED_OFF 4'h5

// ****************************************
// Timing
// ****************************************
`define PCL_CLK_MHZ 100
`define PCL_RST_EXT_US 258
`define PCL_RST_CYC (`PCL_RST_EXT_US * `PCL_CLK_MHZ)
`define PCL_CNT_W 15
`define PCL_SAMPLE_CYC 15'h0004

// ****************************************
// Reset sequencer states
// ****************************************
`define PCL_ST_RESET 2'h0
`define PCL_ST_SAMPLE 2'h1
`define PCL_ST_RUN 2'h2

`endif

// ---- hdl/pcl_pin_ctrl.v ----
// Control and strap pin logic of a 10/100 transceiver, with APB registers
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcl_defs.vh"

// Function
// RULE_01 - Reset pin OR software reset bit
// RULE_02 - Internal reset lasts 258 us
// RULE_03 - Pause strap high advertises pause
// RULE_04 - Sleep pin permits low-power sleep
// RULE_05 - Managed mode: register overrides sleep pin
// RULE_06 - Power-down pin high holds power-down
// RULE_07 - Indicator pins show configured status
// RULE_08 - Indicator pins sampled as straps first
// RULE_09 - Managed: pins set only reset defaults; code: pause only, sleep pin live unless overridden, power-down pin live
// RULE_10 - Address straps captured, match frames only
module pcl_pin_ctrl #(
	parameter RST_CYC = `PCL_RST_CYC
) (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Hardware control pins
	input wire reset_pin_n,
	input wire pause_pin,
	input wire sleep_pin,
	input wire power_down_pin,
	input wire management_port_disable,
	input wire phy_address_strap_msb,
	input wire [3:1] phy_address_strap_mid,
	input wire phy_address_strap_lsb,
	// Indicator / strap pins, three signals each
	input wire [3:1] indicator_strap_in,
	output reg [3:1] indicator_strap_out,
	output reg [3:1] indicator_strap_oe,
	// Link status feeding the indicators
	input wire link_up,
	input wire activity,
	input wire speed_100,
	input wire full_duplex,
	// Management frame address check
	input wire [4:0] frame_phy_addr,
	output wire frame_addr_match,
	// Outputs to the transceiver core
	output reg core_reset,
	output reg pause_advertise,
	output reg sleep_allowed,
	output reg power_down,
	output reg [4:0] phy_address,
	output reg [3:1] strap_config,
	output reg managed_mode
);

	// ****************************************
	// Local constants
	// ****************************************
	// Last count of the stretch, cut to the counter width on purpose
	localparam integer RST_LAST_I = RST_CYC - 1;
	localparam [`PCL_CNT_W-1:0] RST_LAST = RST_LAST_I[`PCL_CNT_W-1:0];
	localparam [`PCL_CNT_W-1:0] CNT_ONE = {{(`PCL_CNT_W-1){1'b0}}, 1'b1};
	// Sequencer states
	localparam [1:0] ST_RESET = `PCL_ST_RESET;
	localparam [1:0] ST_SAMPLE = `PCL_ST_SAMPLE;
	localparam [1:0] ST_RUN = `PCL_ST_RUN;

	// ****************************************
	// Internal state
	// ****************************************
	// Register file
	reg [3:0] ctrl_q;
	reg [11:0] ledcfg_q;
	// Sequencer
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`PCL_CNT_W-1:0] cnt_q;
	reg [`PCL_CNT_W-1:0] cnt_d;
	// Pause default captured with the straps
	reg pause_def_q;
	// Read wait state
	reg rd_done_q;
	// Bus decode
	wire acc;
	wire wr_en;
	wire rd_en;
	wire rd_take;
	wire addr_ok;
	// Reset merge and phase decode
	wire rst_req;
	wire in_reset;
	wire in_sample;
	wire in_run;
	wire last_cnt;
	// Next values of the core controls
	reg pause_adv_d;
	reg sleep_allowed_d;
	// Status picked for each indicator
	wire [3:1] led_val;

	// ****************************************
	// APB access
	// ****************************************
	// Writes finish in their first access cycle. A read takes one wait
	// state: the word is registered first and pready follows, so prdata
	// already stands at the edge where the master samples pready.
	assign acc = psel & penable;
	assign wr_en = acc & pwrite;
	assign rd_en = acc & ~pwrite;
	assign rd_take = rd_en & ~rd_done_q;
	assign pready = ~rd_en | rd_done_q;
	// Unmapped offsets read zero and flag an error
	assign addr_ok = (paddr == `PCL_ADDR_CTRL) |
		(paddr == `PCL_ADDR_LEDCFG) | (paddr == `PCL_ADDR_STATUS) |
		(paddr == `PCL_ADDR_STRAPS);
	assign pslverr = acc & ~addr_ok;

	// Wait-state flag, cleared as soon as the access phase ends
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= rd_take;
		end
	end

	// Read data is registered in the first access cycle of a read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_take) begin
			case (paddr)
			`PCL_ADDR_CTRL: prdata <= {28'h0, ctrl_q};
			`PCL_ADDR_LEDCFG: prdata <= {20'h0, ledcfg_q};
			`PCL_ADDR_STATUS: prdata <= {26'h0, state_q, managed_mode,
				power_down, sleep_allowed, pause_advertise};
			`PCL_ADDR_STRAPS: prdata <= {24'h0, strap_config, phy_address};
			default: prdata <= 32'h0;
			endcase
		end
	end

	// Control and indicator configuration registers. The software reset
	// bit clears itself once the sequencer is in reset, or it would hold
	// the count at zero for ever; a write on that edge wins.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PCL_CTRL_RST_VAL;
			ledcfg_q <= `PCL_LEDCFG_RST;
		end else if (in_sample) begin
			// RULE_09 pins load defaults
			ctrl_q[`PCL_CTRL_PAUSE] <= pause_def_q;
			ctrl_q[`PCL_CTRL_SWRST] <= 1'b0;
		end else begin
			if (in_reset) begin
				ctrl_q[`PCL_CTRL_SWRST] <= 1'b0;
			end
			if (wr_en && paddr == `PCL_ADDR_CTRL) begin
				ctrl_q <= pwdata[3:0];
			end
			if (wr_en && paddr == `PCL_ADDR_LEDCFG) begin
				ledcfg_q <= pwdata[11:0];
			end
		end
	end

	// ****************************************
	// Reset sequencer
	// ****************************************
	// Any reset request restarts the count, so the stretch runs from the
	// last asserted cycle. The request is honoured in every state, so a
	// one-cycle pulse on the reset pin is never lost. Straps are sampled
	// in the last counted cycle, defaults loaded in the sample cycle.
	// RULE_01 reset condition merge
	assign rst_req = ~reset_pin_n | ctrl_q[`PCL_CTRL_SWRST];
	// Phase decode shared by the processes above and below
	assign in_reset = (state_q == ST_RESET);
	assign in_sample = (state_q == ST_SAMPLE);
	assign in_run = (state_q == ST_RUN);
	assign last_cnt = in_reset && (cnt_q == RST_LAST);

	// Next state: a request restarts the count in every state
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (rst_req) begin
			state_d = ST_RESET;
			cnt_d = {`PCL_CNT_W{1'b0}};
		end else begin
			case (state_q)
			ST_RESET: begin
				// RULE_02 extend reset
				if (cnt_q == RST_LAST) begin
					state_d = ST_SAMPLE;
				end else begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			ST_SAMPLE: begin
				state_d = ST_RUN;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RESET;
				cnt_d = {`PCL_CNT_W{1'b0}};
			end
			endcase
		end
	end

	// Sequencer registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RESET;
			cnt_q <= {`PCL_CNT_W{1'b0}};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Strap capture in the last counted cycle, pins still released
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_address <= 5'h0;
			strap_config <= 3'h0;
			managed_mode <= 1'b0;
			pause_def_q <= 1'b0;
		end else if (last_cnt) begin
			// RULE_10 capture address
			phy_address <= {phy_address_strap_msb, phy_address_strap_mid,
				phy_address_strap_lsb};
			// RULE_08 sample indicator straps
			strap_config <= indicator_strap_in;
			managed_mode <= ~management_port_disable;
			pause_def_q <= pause_pin;
		end
	end

	// RULE_10 address match
	assign frame_addr_match = managed_mode && in_run &&
		(frame_phy_addr == phy_address);

	// ****************************************
	// Core control outputs
	// ****************************************
	// Managed mode takes pause from a register bit loaded from its pin at reset,
	// and sleep from the register only when overridden; otherwise the pins act live
	always @* begin
		// RULE_03 pause advertise
		if (managed_mode) begin
			pause_adv_d = ctrl_q[`PCL_CTRL_PAUSE];
		end else begin
			pause_adv_d = pause_pin;
		end
		// RULE_04 RULE_05 sleep select
		if (managed_mode && ctrl_q[`PCL_CTRL_SLEEP_OVR]) begin
			sleep_allowed_d = ctrl_q[`PCL_CTRL_SLEEP_VAL];
		end else begin
			sleep_allowed_d = sleep_pin;
		end
	end

	// Core control registers; power down never resets the block, it
	// only gates the indicator drive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset <= 1'b1;
			pause_advertise <= 1'b0;
			sleep_allowed <= 1'b0;
			power_down <= 1'b0;
		end else begin
			core_reset <= !in_run;
			pause_advertise <= pause_adv_d;
			sleep_allowed <= sleep_allowed_d;
			// RULE_06 power down follows pin
			power_down <= power_down_pin;
		end
	end

	// ****************************************
	// Indicator drivers
	// ****************************************
	// Each pin picks its status from a four-bit field; unused codes read
	// as off, so a stray write cannot light a pin
	genvar gi;
	generate
		for (gi = 1; gi <= 3; gi = gi + 1) begin : g_led
			wire [`PCL_LED_W-1:0] code;
			reg sel;
			assign code = ledcfg_q[gi*`PCL_LED_W-1 -: `PCL_LED_W];
			// RULE_07 status select
			always @* begin
				case (code)
				`PCL_LED_LINK: sel = link_up;
				`PCL_LED_ACT: sel = activity;
				`PCL_LED_SPEED: sel = speed_100;
				`PCL_LED_DUPLEX: sel = full_duplex;
				`PCL_LED_ON: sel = 1'b1;
				default: sel = 1'b0;
				endcase
			end
			assign led_val[gi] = sel;
		end
	endgenerate

	// Pins stay released until straps are sampled, and while powered down
	// RULE_08 release for strap sampling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_strap_out <= 3'h0;
			indicator_strap_oe <= 3'h0;
		end else begin
			indicator_strap_out <= led_val;
			indicator_strap_oe <= {3{in_run && !power_down_pin}};
		end
	end

endmodule // pcl_pin_ctrl

`default_nettype wire

// ---- test/pcl_board.sv ----
// Board model: strap resistors on the shared pins
`timescale 1ns/1ps
`default_nettype none
module pcl_board #(parameter logic [3:1] STRAPS = 3'h5) (
	// Drive from the block
	input wire logic [3:1] indicator_strap_out,
	input wire logic [3:1] indicator_strap_oe,
	// Level at the pins
	output wire logic [3:1] indicator_strap_in
);
	// Undriven pins fall to the strap level, never float
	assign indicator_strap_in = (indicator_strap_oe & indicator_strap_out)
		| (~indicator_strap_oe & STRAPS);
endmodule // pcl_board
`default_nettype wire

// ---- test/pcl_pin_ctrl_sva.sv ----
// Assertion checker for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pcl_pin_ctrl_sva #(parameter RST_CYC = 8) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and core outputs
	input wire logic reset_pin_n,
	input wire logic pause_pin,
	input wire logic sleep_pin,
	input wire logic power_down_pin,
	input wire logic [4:0] frame_phy_addr,
	input wire logic frame_addr_match,
	input wire logic core_reset,
	input wire logic pause_advertise,
	input wire logic sleep_allowed,
	input wire logic power_down,
	input wire logic [4:0] phy_address,
	input wire logic [3:1] indicator_strap_oe,
	input wire logic managed_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PIN_RST: assert property (!reset_pin_n |-> ##2 core_reset)
		else $error("pin reset missed");
	// Eight cycles is the shortest legal stretch in this bench
	AST_STRETCH: assert property ($rose(core_reset) |-> core_reset[*8])
		else $error("reset too short");
	AST_PAUSE: assert property (!core_reset && !managed_mode |=>
		pause_advertise == $past(pause_pin)) else $error("pause wrong");
	AST_SLEEP: assert property (!core_reset && !managed_mode |=>
		sleep_allowed == $past(sleep_pin)) else $error("sleep wrong");
	AST_PDOWN: assert property (!core_reset |=>
		power_down == $past(power_down_pin)) else $error("pd wrong");
	AST_NO_DRIVE: assert property (core_reset |-> !indicator_strap_oe)
		else $error("pins driven in reset");
	AST_HOLD: assert property (!core_reset && $stable(core_reset) |->
		$stable(phy_address) && $stable(managed_mode)) else $error("straps moved");
	AST_MATCH: assert property (frame_addr_match |-> managed_mode &&
		frame_phy_addr == phy_address) else $error("bad match");
	cover property ($rose(core_reset));
	cover property (frame_addr_match);
	cover property (managed_mode && sleep_allowed);
endmodule // pcl_pin_ctrl_sva
`default_nettype wire

// ---- test/pcl_pin_ctrl_test.sv ----
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pcl_pin_ctrl_test;
	// Block pins and bench state
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, reset_pin_n = 1, pause_pin = 0;
	logic sleep_pin = 0, power_down_pin = 0, management_port_disable = 1;
	logic phy_address_strap_msb = 1, phy_address_strap_lsb = 1;
	logic [3:1] phy_address_strap_mid = 3'h2, indicator_strap_in;
	logic [3:1] indicator_strap_out, indicator_strap_oe, strap_config;
	logic link_up = 1, activity = 0, speed_100 = 1, full_duplex = 0;
	logic [4:0] frame_phy_addr = 5'h15, phy_address;
	logic frame_addr_match, core_reset, pause_advertise, sleep_allowed;
	logic power_down, managed_mode;
	int mismatches = 0, n_compared = 0, cyc = 0, n;
	pcl_pin_ctrl #(.RST_CYC(8)) pcl_pin_ctrl_i (.*);
	pcl_board pcl_board_i (.*);
	initial forever #5 pclk = ~pclk;
	// Cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			final_report;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task wait_run;
		for (n = 0; core_reset !== 0 && n < 99; n++) @(posedge pclk) #1;
	endtask
	task boot(input logic mdis);
		@(posedge pclk);
		presetn <= 0;
		management_port_disable <= mdis;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		wait_run;
	endtask
	task t_unmanaged;
		chk({managed_mode, strap_config, phy_address}, 9'h0b5);
		apb(0, 12'h00c, 0);
		chk(rd, 32'hb5);
		apb(0, 12'h010, 0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		for (int v = 1; v >= 0; v--) begin
			@(posedge pclk) {pause_pin, sleep_pin, power_down_pin} <= {3{v[0]}};
			repeat (2) @(posedge pclk);
			#1 chk(pause_advertise, v);
			chk(sleep_allowed, v);
			chk(power_down, v);
		end
		chk(frame_addr_match, 0);
		@(posedge pclk) reset_pin_n <= 0;
		@(posedge pclk) reset_pin_n <= 1;
		repeat (3) @(posedge pclk);
		#1 chk(core_reset, 1);
		wait_run;
		chk(n > 4 && n < 20, 1);
	endtask
	task t_managed;
		chk({managed_mode, frame_addr_match}, 2'h3);
		@(posedge pclk) frame_phy_addr <= 5'h14;
		#1 chk(frame_addr_match, 0);
		@(posedge pclk) frame_phy_addr <= 5'h15;
		@(posedge pclk) #1 chk({indicator_strap_oe, indicator_strap_out}, 6'h3d);
		apb(1, 12'h004, 32'h354);
		repeat (2) @(posedge pclk);
		#1 chk(indicator_strap_in, 3'h1);
		apb(1, 12'h000, 32'he);
		repeat (2) @(posedge pclk);
		#1 chk({pause_advertise, sleep_allowed}, 2'h3);
		@(posedge pclk) sleep_pin <= 1;
		apb(1, 12'h000, 32'h2);
		repeat (2) @(posedge pclk);
		#1 chk({pause_advertise, sleep_allowed}, 2'h0);
		@(posedge pclk) pause_pin <= 1;
		apb(1, 12'h000, 32'h1);
		repeat (3) @(posedge pclk);
		#1 chk({core_reset, indicator_strap_in}, 4'hd);
		wait_run;
		chk(core_reset, 0);
		apb(0, 12'h000, 0);
		chk(rd, 32'h8);
		@(posedge pclk) pause_pin <= 0;
		repeat (2) @(posedge pclk);
		#1 chk({pause_advertise, sleep_allowed}, 2'h3);
		apb(0, 12'h008, 0);
		chk(rd, 32'h2b);
	endtask
	task final_report;
		$display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		boot(1);
		t_unmanaged;
		boot(0);
		t_managed;
		final_report;
	end
endmodule // pcl_pin_ctrl_test
bind pcl_pin_ctrl pcl_pin_ctrl_sva #(.RST_CYC(RST_CYC)) pcl_pin_ctrl_sva_i (
	.pclk(pclk),
	.presetn(presetn),
	.reset_pin_n(reset_pin_n),
	.pause_pin(pause_pin),
	.sleep_pin(sleep_pin),
	.power_down_pin(power_down_pin),
	.frame_phy_addr(frame_phy_addr),
	.frame_addr_match(frame_addr_match),
	.core_reset(core_reset),
	.pause_advertise(pause_advertise),
	.sleep_allowed(sleep_allowed),
	.power_down(power_down),
	.phy_address(phy_address),
	.indicator_strap_oe(indicator_strap_oe),
	.managed_mode(managed_mode)
);
`default_nettype wire
